// *** logic/fbs_pkg.sv ***
`default_nettype none
package fbs_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_EPWM_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BRIDGE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS      = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h10;

  // ==========================================================
  // field positions
  localparam int RESTART_EN_BIT   = 7;
  localparam int DELAY_MSB        = 6;
  localparam int BRIDGE_EN_BIT    = 0;
  localparam int DIRECTION_BIT    = 1;
  localparam int ST_SHUTDOWN_BIT  = 0;
  localparam int ST_APPLIED_BIT   = 1;
  localparam int ST_BLANK_BIT     = 2;
  localparam int IRQ_DIR_DONE_BIT = 0;
  localparam int IRQ_SHUTDOWN_BIT = 1;
  localparam int IRQ_W            = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] EPWM_CTRL_RST   = 8'h00;
  localparam logic [1:0] BRIDGE_CTRL_RST = 2'h0;
  localparam logic [1:0] IRQ_RST         = 2'h0;

  // ==========================================================
  // timing
  localparam int         CLK_MHZ        = 100;
  localparam int         OSC_PER_INSTR  = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(OSC_PER_INSTR - 1);
  localparam logic [7:0] PRE_END_COUNTS = 8'h04;

  // ==========================================================
  // ahb-lite
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ==========================================================
  // steering sequencer, gray along run -> blank -> run
  typedef enum logic [1:0] {
    FBS_RUN   = 2'b00,
    FBS_BLANK = 2'b01
  } fbs_state_type;

endpackage
`default_nettype wire

// *** logic/fbs_top.sv ***
// Contract
// - in full-bridge use all four bridge outputs are driven and only one is modulated.
// - forward: a held active, d modulated, b and c held inactive.
// - reverse: c held active, b modulated, a and d held inactive.
// - a written direction_select takes effect from the next pwm cycle only.
// - on a direction change b and d go inactive four timer counts before period end.
// - at that same point a and c switch over to the new direction.
// - modulation of the new output resumes at the start of the next period.
// - no dead band is inserted between bridge output transitions.
// - auto_restart_enable (bit 7) set clears the shutdown flag when the event ends.
// - active_delay_count (bits 6-0) delays active-going edges by that many instr clocks.
// - control register resets to zero and reads zero under the clock-mode condition.
`default_nettype none
module fbs_top (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        clk_en,
  input  wire  logic        hsel,
  input  wire  logic [7:0]  haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic        hready,
  input  wire  logic [31:0] hwdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire  logic        pwm_raw,
  input  wire  logic [7:0]  timer_count,
  input  wire  logic [7:0]  timer_period,
  input  wire  logic        period_start,
  input  wire  logic        shutdown_event,
  input  wire  logic        two_speed_xtal,
  input  wire  logic        fail_safe_en,
  output logic              bridge_out_a,
  output logic              bridge_out_b,
  output logic              bridge_out_c,
  output logic              bridge_out_d,
  output logic [3:0]        bridge_oe,
  output logic              irq
);

  // ==========================================================
  // register state
  logic [7:0]           epwm_ctrl_q;
  logic [1:0]           bridge_ctrl_q;
  logic [fbs_pkg::IRQ_W-1:0] irq_status_q;
  logic [fbs_pkg::IRQ_W-1:0] irq_mask_q;
  logic                 shutdown_event_status_q;
  logic                 dir_applied_q;
  fbs_pkg::fbs_state_type state_q;

  // ==========================================================
  // ahb-lite address phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        accept;
  logic        ctrl_masked;
  logic        full_bridge;
  logic        direction_select;
  logic        auto_restart_enable;
  logic [6:0]  active_delay_count;

  assign accept = hsel & hready & htrans[1] & clk_en;
  // bus stalls while the block is frozen
  assign hreadyout = clk_en;
  assign hresp     = fbs_pkg::HRESP_OKAY;

  // clock-mode condition hides the whole register
  assign ctrl_masked = two_speed_xtal | fail_safe_en;
  assign auto_restart_enable =
    epwm_ctrl_q[fbs_pkg::RESTART_EN_BIT] & ~ctrl_masked;
  assign active_delay_count =
    ctrl_masked ? 7'h00 : epwm_ctrl_q[fbs_pkg::DELAY_MSB:0];
  assign full_bridge      = bridge_ctrl_q[fbs_pkg::BRIDGE_EN_BIT];
  assign direction_select = bridge_ctrl_q[fbs_pkg::DIRECTION_BIT];

  function automatic logic is_wr(input logic [7:0] a);
    is_wr = wr_pend_q & (wr_addr_q == a);
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      fbs_pkg::ADDR_EPWM_CTRL: begin
        read_mux[7:0] = ctrl_masked ? 8'h00 : epwm_ctrl_q;
      end
      fbs_pkg::ADDR_BRIDGE_CTRL: begin
        read_mux[1:0] = bridge_ctrl_q;
      end
      fbs_pkg::ADDR_STATUS: begin
        read_mux[fbs_pkg::ST_SHUTDOWN_BIT] = shutdown_event_status_q;
        read_mux[fbs_pkg::ST_APPLIED_BIT]  = dir_applied_q;
        read_mux[fbs_pkg::ST_BLANK_BIT]    =
          (state_q == fbs_pkg::FBS_BLANK);
      end
      fbs_pkg::ADDR_IRQ_STATUS: begin
        read_mux[fbs_pkg::IRQ_W-1:0] = irq_status_q;
      end
      fbs_pkg::ADDR_IRQ_MASK: begin
        read_mux[fbs_pkg::IRQ_W-1:0] = irq_mask_q;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_q <= accept & hwrite;
      if (accept) begin
        wr_addr_q <= haddr;
      end
      // read data prepared at the address phase, stands in data phase
      if (accept && !hwrite) begin
        hrdata <= read_mux(haddr);
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      epwm_ctrl_q   <= fbs_pkg::EPWM_CTRL_RST;
      bridge_ctrl_q <= fbs_pkg::BRIDGE_CTRL_RST;
      irq_mask_q    <= fbs_pkg::IRQ_RST;
    end else if (clk_en) begin
      // writes are dropped while the register is hidden
      if (is_wr(fbs_pkg::ADDR_EPWM_CTRL) && !ctrl_masked) begin
        epwm_ctrl_q <= hwdata[7:0];
      end
      if (is_wr(fbs_pkg::ADDR_BRIDGE_CTRL)) begin
        bridge_ctrl_q <= hwdata[1:0];
      end
      if (is_wr(fbs_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_q <= hwdata[fbs_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // shutdown flag
  logic sw_clear_shutdown;
  assign sw_clear_shutdown = is_wr(fbs_pkg::ADDR_STATUS) &
                             hwdata[fbs_pkg::ST_SHUTDOWN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown_event_status_q <= 1'b0;
    end else if (clk_en) begin
      // set wins: a live event keeps the flag up
      if (shutdown_event) begin
        shutdown_event_status_q <= 1'b1;
      end else if (auto_restart_enable) begin
        shutdown_event_status_q <= 1'b0;
      end else if (sw_clear_shutdown) begin
        shutdown_event_status_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // direction sequencer
  logic pre_end;
  logic dir_pending;
  // two register stages (state, outputs) lie between compare and pins,
  // so compare early enough that the swap shows four counts before end
  assign pre_end = (timer_count ==
                    8'(timer_period - (fbs_pkg::PRE_END_COUNTS + 8'h01)));
  assign dir_pending = direction_select != dir_applied_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q       <= fbs_pkg::FBS_RUN;
      dir_applied_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        fbs_pkg::FBS_RUN: begin
          // untouched direction: no blanking at the boundary
          if (dir_pending && pre_end && full_bridge) begin
            state_q       <= fbs_pkg::FBS_BLANK;
            dir_applied_q <= direction_select;
          end else if (!full_bridge) begin
            dir_applied_q <= direction_select;
          end
        end
        fbs_pkg::FBS_BLANK: begin
          if (period_start) begin
            state_q <= fbs_pkg::FBS_RUN;
          end
        end
        default: begin
          state_q <= fbs_pkg::FBS_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // active-going edge delay in instruction clocks
  logic [1:0] div_q;
  logic       instr_tick;
  logic [6:0] delay_q;
  logic       pwm_prev_q;
  logic       pwm_del_q;

  assign instr_tick = (div_q == fbs_pkg::INSTR_DIV_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 2'h0;
    end else if (clk_en) begin
      div_q <= 2'(div_q + 2'h1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_prev_q <= 1'b0;
      pwm_del_q  <= 1'b0;
      delay_q    <= 7'h00;
    end else if (clk_en) begin
      pwm_prev_q <= pwm_raw;
      if (!pwm_raw) begin
        // inactive-going edges pass at once
        pwm_del_q <= 1'b0;
        delay_q   <= 7'h00;
      end else if (!pwm_prev_q) begin
        if (active_delay_count == 7'h00) begin
          pwm_del_q <= 1'b1;
        end else begin
          delay_q <= active_delay_count;
        end
      end else if (delay_q != 7'h00) begin
        if (instr_tick) begin
          delay_q <= 7'(delay_q - 7'h01);
          if (delay_q == 7'h01) begin
            pwm_del_q <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // output steering, registered, no dead band between edges
  logic mod_live;
  assign mod_live = pwm_del_q & (state_q == fbs_pkg::FBS_RUN) &
                    ~shutdown_event_status_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bridge_out_a <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_out_c <= 1'b0;
      bridge_out_d <= 1'b0;
      bridge_oe    <= 4'h0;
    end else if (clk_en) begin
      bridge_oe <= {4{full_bridge}};
      if (!full_bridge || shutdown_event_status_q) begin
        bridge_out_a <= 1'b0;
        bridge_out_b <= 1'b0;
        bridge_out_c <= 1'b0;
        bridge_out_d <= 1'b0;
      end else if (!dir_applied_q) begin
        bridge_out_a <= 1'b1;
        bridge_out_b <= 1'b0;
        bridge_out_c <= 1'b0;
        bridge_out_d <= mod_live;
      end else begin
        bridge_out_a <= 1'b0;
        bridge_out_b <= mod_live;
        bridge_out_c <= 1'b1;
        bridge_out_d <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupts, write one to clear, set wins
  logic [fbs_pkg::IRQ_W-1:0] irq_set;
  logic [fbs_pkg::IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[fbs_pkg::IRQ_DIR_DONE_BIT] =
      (state_q == fbs_pkg::FBS_BLANK) & period_start;
    irq_set[fbs_pkg::IRQ_SHUTDOWN_BIT] =
      shutdown_event & ~shutdown_event_status_q;
    irq_clr = is_wr(fbs_pkg::ADDR_IRQ_STATUS) ?
              hwdata[fbs_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= fbs_pkg::IRQ_RST;
    end else if (clk_en) begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

endmodule
`default_nettype wire

// *** dv/fbs_properties.sv ***
`default_nettype none
module fbs_properties (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hresp,
  input wire logic       pwm_raw,
  input wire logic       shutdown_event,
  input wire logic       bridge_out_a,
  input wire logic       bridge_out_b,
  input wire logic       bridge_out_c,
  input wire logic       bridge_out_d,
  input wire logic [3:0] bridge_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // steering
  a_one_modulated: assert property (!(bridge_out_b && bridge_out_d))
    else $error("both modulated outputs high");
  a_outputs_enabled: assert property (
    (bridge_out_a || bridge_out_b || bridge_out_c || bridge_out_d)
    |-> bridge_oe == 4'hf) else $error("output high while not enabled");
  a_forward_hold: assert property (
    bridge_out_a |-> !bridge_out_b && !bridge_out_c)
    else $error("forward leg conflict");
  a_reverse_hold: assert property (
    bridge_out_c |-> !bridge_out_a && !bridge_out_d)
    else $error("reverse leg conflict");
  // two cycles of pipeline, so three low cycles must clear it
  a_mod_release: assert property (!pwm_raw [*3]
    |-> !bridge_out_b && !bridge_out_d) else $error("modulation stuck");
  a_switch_blank: assert property (
    $changed(bridge_out_a) && $changed(bridge_out_c)
    |-> (!bridge_out_b && !bridge_out_d) [*3]) else $error("no blanking");
  a_no_deadband: assert property (
    $fell(bridge_out_a) && bridge_oe == 4'hf && !shutdown_event
    && !$past(shutdown_event) |-> bridge_out_c) else $error("gap in swap");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  c_swap: cover property ($changed(bridge_out_a) && $changed(bridge_out_c));
  c_shut: cover property ($fell(bridge_out_a) && shutdown_event);
  c_rev: cover property ($rose(bridge_out_b));
endmodule
bind fbs_top fbs_properties chk_u (.hclk, .hresetn, .hresp, .pwm_raw,
  .shutdown_event, .bridge_out_a, .bridge_out_b, .bridge_out_c,
  .bridge_out_d, .bridge_oe);
`default_nettype wire

// *** dv/fbs_bridge_model.sv ***
`default_nettype none
module fbs_bridge_model (
  input wire logic       hclk,
  input wire logic [3:0] gate,
  input wire logic [3:0] oe,
  output var int         shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv;
  // undriven gates sit on their pull-downs, so count as off
  assign drv = gate & oe;
  initial shoot_cnt = 0;
  // legs are a over b and c over d
  always @(posedge hclk) begin
    if ((drv[0] && drv[1]) || (drv[2] && drv[3])) begin
      shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** dv/full_bridge_pwm_steering_tb.sv ***
`default_nettype none
module full_bridge_pwm_steering_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
  localparam logic [7:0] PER = 8'h27;
  localparam logic [7:0] CTL = fbs_pkg::ADDR_EPWM_CTRL;
  localparam logic [7:0] BRG = fbs_pkg::ADDR_BRIDGE_CTRL;
  localparam logic [7:0] STA = fbs_pkg::ADDR_STATUS;
  logic        hclk, hresetn, hsel, hwrite, pwm, pstart, sd, tsx, fse;
  logic        hreadyout, hresp, irq, a, b, c, d;
  logic [1:0]  htrans;
  logic [3:0]  oe, outs;
  logic [7:0]  haddr, tcnt, duty, r;
  logic [31:0] hwdata, hrdata, v;
  int          err_total, samples_checked, cyc, shoot;
  assign outs = {d, c, b, a};
  fbs_top dut_u (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hresp,
    .hrdata, .pwm_raw(pwm), .timer_count(tcnt), .timer_period(PER),
    .period_start(pstart), .shutdown_event(sd), .two_speed_xtal(tsx),
    .fail_safe_en(fse), .bridge_out_a(a), .bridge_out_b(b),
    .bridge_out_c(c), .bridge_out_d(d), .bridge_oe(oe), .irq);
  fbs_bridge_model load_u (.hclk, .gate(outs), .oe, .shoot_cnt(shoot));
  // ==========================================================
  // clock, period timer and raw modulation
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    tcnt <= (tcnt == PER) ? 8'h00 : tcnt + 8'h01;
    pstart <= (tcnt == PER);
    pwm <= (((tcnt == PER) ? 8'h00 : tcnt + 8'h01) < duty);
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [3:0] exp_out(input logic rev, input logic on);
    return rev ? {2'b01, on, 1'b0} : {on, 3'b001};
  endfunction
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= ad;
    htrans <= fbs_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask
  task automatic rdk(input logic [7:0] ad, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, ad, 32'h0000_0000);
    `CHK(v & m, e)
  endtask
  task automatic wait_cnt(input logic [7:0] t);
    do @(posedge hclk); while (tcnt !== t);
  endtask
  task automatic check_period(input logic rev);
    wait_cnt(8'h00);
    wait_cnt(duty - 8'h01);
    `CHK(outs, exp_out(rev, 1'b1))
    wait_cnt(duty + 8'h03);
    `CHK(outs, exp_out(rev, 1'b0))
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    {hresetn, hsel, hwrite, sd, tsx, fse, pwm, pstart} = '0;
    {htrans, haddr, tcnt, duty, hwdata} = '0;
    void'($urandom(51657));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdk(CTL, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 1; i < 3; i++) begin
      tsx <= i[0];
      fse <= i[1];
      wr(CTL, $urandom);
      rdk(CTL, 32'hFFFF_FFFF, 32'h0000_0000);
    end
    {tsx, fse} <= 2'b00;
    r = 8'($urandom);
    wr(CTL, {24'h0, r});
    rdk(CTL, 32'hFFFF_FFFF, {24'h0, r});
    rdk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    done("registers");
    wr(CTL, 32'h0000_0000);
    wr(BRG, 32'h0000_0001);
    repeat (3) begin
      duty <= 8'(8 + $urandom % 23);
      check_period(1'b0);
    end
    `CHK(oe, 4'hf)
    done("forward");
    for (int i = 1; i >= 0; i--) begin
      duty <= 8'h08;
      wait_cnt(8'h02);
      wr(BRG, {30'h0, i[0], 1'b1});
      wait_cnt(PER - 8'h04);
      `CHK(outs, exp_out(!i[0], 1'b0))
      wait_cnt(PER - 8'h03);
      `CHK(outs, exp_out(i[0], 1'b0))
      check_period(i[0]);
      rdk(fbs_pkg::ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(fbs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      @(posedge hclk);
      `CHK(irq, 1'b1)
      wr(fbs_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
      @(posedge hclk);
      `CHK(irq, 1'b0)
    end
    done("direction");
    duty <= PER + 8'h01;
    wait_cnt(PER);
    wait_cnt(PER);
    `CHK(outs, exp_out(1'b0, 1'b1))
    r = 8'(1 + $urandom % 4);
    duty <= 8'h1e;
    wr(CTL, {24'h0, r});
    wait_cnt(PER);
    // instruction clock phase is free running: allow its jitter
    wait_cnt(r * 8'h04 - 8'h02);
    `CHK(d, 1'b0)
    wait_cnt(r * 8'h04 + 8'h07);
    `CHK(d, 1'b1)
    done("delay");
    for (int i = 0; i < 2; i++) begin
      wr(CTL, {24'h0, i[0], 7'h00});
      sd <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK(outs, 4'h0)
      sd <= 1'b0;
      repeat (4) @(posedge hclk);
      rdk(STA, 32'h0000_0001, {31'h0, ~i[0]});
      wr(STA, 32'h0000_0001);
      rdk(STA, 32'h0000_0001, 32'h0000_0000);
    end
    done("shutdown");
    `CHK(shoot, 0)
    close_out();
  end
endmodule
`default_nettype wire
